// >>> rtl/cs100_adapter.sv
// Processor to system bus adapter with an AXI4-Lite control port.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps

`include "cs100_map.svh"

// Functional notes
// - Mirror low address onto high for I/O.
// - Otherwise high address drives upper lines.
// - Address disable floats address drivers.
// - Status on data out during sync.
// - Data out disable floats data drivers.
// - Data in off unless read or DMA.
// - Data in off for internal sources.
// - Sync starts on first strobe, no refresh.
// - No sync on refresh memory request.
// - Sync ends on phase-two edge by cycle.
// - I/O cycle sync arrives in T2.
// - Write strobe only outside sync.
// - Read strobe is read or acknowledge.
// - Watch opcode bits except D3.
// - Load interrupt flag from D3 at fetch end.
// - Reset or acknowledge clears interrupt flag.
// - Hold acknowledge is inverted bus grant.
// - Wait set at once, cleared on 8 MHz tick.
// - Acknowledge is fetch and I/O together.
// - Wait sources: ready lines, fetch, slow ROM.
// - Status gated with early write, acknowledge bits.
module cs100_adapter
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [7:0]  cpu_dout,
	output logic [7:0]       cpu_din,
	input  wire logic        opcode_fetch_n,
	input  wire logic        mem_request_n,
	input  wire logic        io_request_n,
	input  wire logic        cpu_rd_n,
	input  wire logic        cpu_wr_n,
	input  wire logic        cpu_refresh_n,
	input  wire logic        cpu_halt_n,
	input  wire logic        cpu_bus_grant_n,
	input  wire logic        phase2,
	output logic             cpu_wait_n,
	input  wire logic        reset_bus_n,
	input  wire logic        addr_dsb_n,
	input  wire logic        dout_dsb_n,
	input  wire logic        xrdy,
	input  wire logic        prdy,
	input  wire logic        rom_select,
	output logic [15:0]      bus_addr,
	output logic             bus_addr_oe,
	output logic [7:0]       bus_dout,
	output logic             bus_dout_oe,
	input  wire logic [7:0]  bus_din,
	output logic             bus_din_en,
	output logic             bus_sync,
	output logic             bus_wr_n,
	output logic             bus_dbin,
	output logic             bus_inte,
	output logic             bus_hlda,
	output logic             bus_wait,
	output logic             bus_inta
);

	// -------------------------------------------------------------------------
	// Input synchronisers
	// -------------------------------------------------------------------------
	localparam int NSYNC = 14;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sy_in;
	logic [NSYNC-1:0] sy_rst;

	assign raw_in = {opcode_fetch_n, mem_request_n, io_request_n, cpu_rd_n, cpu_wr_n, cpu_refresh_n,
		cpu_halt_n, cpu_bus_grant_n, phase2, reset_bus_n, addr_dsb_n, dout_dsb_n, xrdy, prdy};
	assign sy_rst = 14'h3FDF;

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			cs100_sync3 u_sync
			(
				.aclk    (aclk),
				.aresetn (aresetn),
				.din     (raw_in[gi] ^ sy_rst[gi]),
				.rst_val (sy_rst[gi]),
				.dout    (sy_in[gi])
			);
		end
	endgenerate

	logic m1_n, mem_request_n_n, io_request_n_n, rd_n, wr_n, rfsh_n, halt_n, cpu_bus_grant_n_n, ph2, prst_n, adsb_n, dodsb_n, xr, pr;
	assign {m1_n, mem_request_n_n, io_request_n_n, rd_n, wr_n, rfsh_n, halt_n, cpu_bus_grant_n_n, ph2, prst_n, adsb_n, dodsb_n, xr, pr} = sy_in;

	// -------------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------------
	typedef struct packed
	{
		cs100_pkg::cs100_sync_type sync_st;
		logic        strobe_any;
		logic        m1_prev;
		logic        ph2_prev;
		logic        io_cycle;
		logic        wr_block;
		logic        op_match;
		logic        op_d3;
		logic        inte;
		logic        waitq;
		logic [4:0]  div;
		logic [7:0]  ctrl;
		logic        awtaken;
		logic        wtaken;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic        wstrb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [15:0] addr_q;
		logic [7:0]  dout_q;
	} cs100_state_type;

	cs100_state_type st_reg;
	cs100_state_type st_next;

	logic inta;
	logic sync_on;
	logic tick8;
	logic wait_req;
	logic mirror;
	logic [7:0] status_bits;
	logic opcode_seen;

	// Acknowledge cycle: fetch and I/O request active together.
	assign inta = !m1_n && !io_request_n_n;
	assign sync_on = (st_reg.sync_st == cs100_pkg::CS100_SYNC);
	assign tick8 = (st_reg.div == 5'(`CS100_TICK_DIV - 1));
	assign mirror = st_reg.ctrl[`CS100_CTRL_MIRROR] && !io_request_n_n && m1_n;
	// Opcodes arrive on the bus data in lines during a fetch.
	assign opcode_seen = ((bus_din & `CS100_IRQ_MASK) == `CS100_IRQ_PATTERN);

	// Status word; write and acknowledge bits use early decodes since the
	// processor strobes come too late for the sync window.
	always_comb
	begin
		status_bits = 8'h00;
		status_bits[7] = !mem_request_n_n && !rd_n;
		status_bits[6] = !io_request_n_n && !rd_n;
		status_bits[5] = !m1_n;
		status_bits[4] = !io_request_n_n && !wr_n;
		status_bits[3] = !halt_n;
		status_bits[1] = !((!mem_request_n_n || !io_request_n_n) && rd_n);
		status_bits[0] = !m1_n && rd_n;
	end

	// Wait sources.
	assign wait_req = !xr || !pr || (sync_on && ((!m1_n && st_reg.ctrl[`CS100_CTRL_FWAIT]) ||
		(rom_select && st_reg.ctrl[`CS100_CTRL_SPD4])));

	// -------------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------------
	always_comb
	begin
		logic strobe_now;
		logic ph2_rise;
		logic ph2_fall;
		strobe_now = 1'b0;
		ph2_rise = 1'b0;
		ph2_fall = 1'b0;
		st_next = st_reg;
		strobe_now = !m1_n || !mem_request_n_n || !io_request_n_n;
		ph2_rise = ph2 && !st_reg.ph2_prev;
		ph2_fall = !ph2 && st_reg.ph2_prev;
		st_next.strobe_any = strobe_now;
		st_next.ph2_prev = ph2;
		st_next.m1_prev = m1_n;
		st_next.div = tick8 ? 5'h00 : 5'(st_reg.div + 5'h01);

		// Sync flop sets on the first strobe of a cycle with refresh inactive.
		case (st_reg.sync_st)
			cs100_pkg::CS100_IDLE:
			begin
				if (strobe_now && !st_reg.strobe_any && rfsh_n)
				begin
					st_next.sync_st = cs100_pkg::CS100_SYNC;
					st_next.io_cycle = !m1_n || !io_request_n_n;
				end
			end
			cs100_pkg::CS100_SYNC:
			begin
				if ((st_reg.io_cycle && ph2_rise) || (!st_reg.io_cycle && ph2_fall))
				begin
					st_next.sync_st = cs100_pkg::CS100_AFTER;
				end
			end
			cs100_pkg::CS100_AFTER:
			begin
				if (!strobe_now)
				begin
					st_next.sync_st = cs100_pkg::CS100_IDLE;
				end
			end
			default:
			begin
				st_next.sync_st = cs100_pkg::CS100_IDLE;
			end
		endcase

		// Write block flag: set as sync rises, cleared when it falls.
		if (st_next.sync_st == cs100_pkg::CS100_SYNC)
		begin
			st_next.wr_block = 1'b1;
		end
		else if (sync_on)
		begin
			st_next.wr_block = 1'b0;
		end

		// Opcode match armed during fetch, loaded as fetch ends.
		if (!m1_n && !rd_n)
		begin
			st_next.op_match = opcode_seen;
			st_next.op_d3 = bus_din[`CS100_IRQ_BIT];
		end
		if (!prst_n || inta)
		begin
			st_next.inte = 1'b0;
			st_next.op_match = 1'b0;
		end
		else if (m1_n && !st_reg.m1_prev && st_reg.op_match)
		begin
			st_next.inte = st_reg.op_d3;
			st_next.op_match = 1'b0;
		end

		// Wait flop: held while requested, released only on the 8 MHz tick.
		if (wait_req)
		begin
			st_next.waitq = 1'b1;
		end
		else if (tick8)
		begin
			st_next.waitq = 1'b0;
		end

		// Registered bus data: status during sync, write data otherwise.
		st_next.dout_q = (st_next.sync_st == cs100_pkg::CS100_SYNC) ? status_bits : cpu_dout;
		st_next.addr_q = {mirror ? cpu_addr[7:0] : cpu_addr[15:8], cpu_addr[7:0]};

		// AXI4-Lite write channel.
		if (s_axi_awvalid && !st_reg.awtaken && !st_reg.bvalid)
		begin
			st_next.awtaken = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.wtaken && !st_reg.bvalid)
		begin
			st_next.wtaken = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb0 = s_axi_wstrb[0];
		end
		if (st_reg.awtaken && st_reg.wtaken)
		begin
			st_next.awtaken = 1'b0;
			st_next.wtaken = 1'b0;
			st_next.bvalid = 1'b1;
			if (st_reg.awaddr[11:2] == 10'(`CS100_CTRL_OFS >> 2))
			begin
				if (st_reg.wstrb0)
				begin
					st_next.ctrl = st_reg.wdata[7:0];
				end
				st_next.bresp = `CS100_RESP_OKAY;
			end
			else if (st_reg.awaddr[11:2] == 10'(`CS100_STATUS_OFS >> 2))
			begin
				st_next.bresp = `CS100_RESP_OKAY;
			end
			else
			begin
				st_next.bresp = `CS100_RESP_SLVERR;
			end
		end
		if (st_reg.bvalid && s_axi_bready)
		begin
			st_next.bvalid = 1'b0;
		end

		// AXI4-Lite read channel.
		if (s_axi_arvalid && !st_reg.rvalid)
		begin
			st_next.rvalid = 1'b1;
			st_next.rdata = 32'h0000_0000;
			st_next.rresp = `CS100_RESP_OKAY;
			if (s_axi_araddr[11:2] == 10'(`CS100_CTRL_OFS >> 2))
			begin
				st_next.rdata = {24'h00_0000, st_reg.ctrl};
			end
			else if (s_axi_araddr[11:2] == 10'(`CS100_STATUS_OFS >> 2))
			begin
				st_next.rdata = {27'h000_0000, inta, !cpu_bus_grant_n_n, st_reg.waitq, st_reg.inte, sync_on};
			end
			else
			begin
				st_next.rresp = `CS100_RESP_SLVERR;
			end
		end
		else if (st_reg.rvalid && s_axi_rready)
		begin
			st_next.rvalid = 1'b0;
		end
	end

	// -------------------------------------------------------------------------
	// Register update
	// -------------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg <= '{sync_st: cs100_pkg::CS100_IDLE, ctrl: 8'(`CS100_CTRL_RST), default: '0};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	// Both disable inputs float the drivers so a DMA master owns the bus.
	assign bus_addr = st_reg.addr_q;
	assign bus_addr_oe = adsb_n;
	assign bus_dout = st_reg.dout_q;
	assign bus_dout_oe = dodsb_n;
	assign bus_sync = sync_on;
	assign bus_wr_n = wr_n || st_reg.wr_block || sync_on;
	assign bus_dbin = !rd_n || inta;
	assign bus_inte = st_reg.inte;
	assign bus_hlda = !cpu_bus_grant_n_n;
	assign bus_wait = st_reg.waitq || wait_req;
	assign cpu_wait_n = !bus_wait;
	assign bus_inta = inta;
	assign cpu_din = bus_din;
	// Data in buffer enabled for reads or DMA, never for internal sources.
	assign bus_din_en = (bus_dbin || !cpu_bus_grant_n_n) && !(rom_select && st_reg.ctrl[`CS100_CTRL_ROMEN]) &&
		!st_reg.ctrl[`CS100_CTRL_SERIAL] && !st_reg.ctrl[`CS100_CTRL_POJ] &&
		!st_reg.ctrl[`CS100_CTRL_FPEXAM];

	assign s_axi_awready = !st_reg.awtaken && !st_reg.bvalid;
	assign s_axi_wready = !st_reg.wtaken && !st_reg.bvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	sequence sync_rise_s;
		!sync_on ##1 sync_on;
	endsequence

	AST_MIRROR: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl[0] && !io_request_n_n && m1_n) |=> (bus_addr[15:8] == $past(cpu_addr[7:0])))
		else $error("Mirrored address missing.");
	AST_NOMIRROR: assert property (@(posedge aclk) disable iff (!aresetn)
		!(st_reg.ctrl[0] && !io_request_n_n && m1_n) |=> (bus_addr[15:8] == $past(cpu_addr[15:8])))
		else $error("High address wrong.");
	AST_DOUT_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
		sync_on |-> (bus_dout == $past(status_bits)))
		else $error("Status not on data out during sync.");
	AST_SYNC_REFRESH: assert property (@(posedge aclk) disable iff (!aresetn)
		sync_rise_s |-> $past(rfsh_n, 1))
		else $error("Sync started during refresh.");
	AST_WR_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
		sync_on |-> bus_wr_n)
		else $error("Write strobe during sync.");
	AST_DBIN: assert property (@(posedge aclk) disable iff (!aresetn)
		bus_dbin == (!rd_n || (!m1_n && !io_request_n_n)))
		else $error("Read strobe wrong.");
	AST_INTE_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
		(!prst_n || inta) |=> !bus_inte)
		else $error("Interrupt flag not cleared.");
	AST_WAIT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.waitq && !wait_req && !tick8) |=> st_reg.waitq)
		else $error("Wait dropped off tick.");
	AST_HLDA: assert property (@(posedge aclk) disable iff (!aresetn)
		bus_hlda != cpu_bus_grant_n_n)
		else $error("Hold acknowledge wrong.");

endmodule

// >>> rtl/cs100_map.svh
// Constants for the processor to system bus adapter.
`ifndef CS100_MAP_SVH
`define CS100_MAP_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define CS100_CTRL_OFS      12'h000
`define CS100_STATUS_OFS    12'h004
`define CS100_CTRL_RST      32'h0000_0001

// -----------------------------------------------------------------------------
// Control field positions
// -----------------------------------------------------------------------------
`define CS100_CTRL_MIRROR   0
`define CS100_CTRL_FWAIT    1
`define CS100_CTRL_ROMEN    2
`define CS100_CTRL_SERIAL   3
`define CS100_CTRL_POJ      4
`define CS100_CTRL_FPEXAM   5
`define CS100_CTRL_SPD4     6

// -----------------------------------------------------------------------------
// Status field positions
// -----------------------------------------------------------------------------
`define CS100_ST_SYNC       0
`define CS100_ST_INTE       1
`define CS100_ST_WAIT       2
`define CS100_ST_HLDA       3
`define CS100_ST_INTA       4

// -----------------------------------------------------------------------------
// Opcode pattern and timing
// -----------------------------------------------------------------------------
`define CS100_IRQ_MASK      8'hF7
`define CS100_IRQ_PATTERN   8'hF3
`define CS100_IRQ_BIT       3
`define CS100_CLK_MHZ       200
`define CS100_TICK_MHZ      8
`define CS100_TICK_DIV      (`CS100_CLK_MHZ / `CS100_TICK_MHZ)
`define CS100_RESP_OKAY     2'h0
`define CS100_RESP_SLVERR   2'h2

`endif

// >>> rtl/cs100_pkg.sv
// Types for the processor to system bus adapter.
package cs100_pkg;

	typedef enum logic [1:0]
	{
		CS100_IDLE  = 2'h0,
		CS100_SYNC  = 2'h1,
		CS100_AFTER = 2'h3
	} cs100_sync_type;

endpackage

// >>> rtl/cs100_sync3.sv
// Three flop input synchroniser with second and third stage agreement.
`timescale 1ns/10ps

`include "cs100_map.svh"

module cs100_sync3
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic din,
	input  wire logic rst_val,
	output logic      dout
);

	typedef struct packed
	{
		logic [2:0] stage;
		logic       value;
	} cs100_sync_state_type;

	cs100_sync_state_type state_reg;
	cs100_sync_state_type state_next;

	// Only the second and third stages are compared; the first feeds nothing else.
	always_comb
	begin
		state_next       = state_reg;
		state_next.stage = {state_reg.stage[1:0], din};
		if (state_reg.stage[1] == state_reg.stage[2])
		begin
			state_next.value = state_reg.stage[2];
		end
	end

	// The reset value comes from a constant tie at the instance.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= '{stage: 3'h0, value: 1'b0};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign dout = state_reg.value ^ rst_val;

endmodule

// >>> verif/cs100_bus_board.sv
// Behavioural memory board on the far side of the system bus.
`timescale 1ns/10ps

module cs100_bus_board
(
	input  wire logic        aclk,
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_dbin,
	input  wire logic        slow,
	output logic [7:0]       bus_din,
	output logic             prdy
);
	logic [7:0] last_reg = 8'h00;
	logic [2:0] hold_reg = 3'h0;
	logic       dbin_reg = 1'b0;
	logic [7:0] word;

	// Addresses whose low nibble is 0 or 1 hold the interrupt opcodes; the rest hold a harmless pattern.
	assign word = (bus_addr[3:0] == 4'h0) ? 8'hFB : (bus_addr[3:0] == 4'h1) ? 8'hF3 : {4'h5, bus_addr[3:0]};

	// A slow board stalls each read it sees; the stall count is short so the bench stays quick.
	always @(posedge aclk)
	begin
		dbin_reg <= bus_dbin;
		if (bus_dbin)
			last_reg <= word;
		if (bus_dbin & ~dbin_reg & slow)
			hold_reg <= 3'h4;
		else if (hold_reg != 3'h0)
			hold_reg <= hold_reg - 3'h1;
	end

	// Released lines show the inverse of the last byte, so stale data never looks valid.
	assign bus_din = bus_dbin ? word : ~last_reg;
	// The ready line drops one clock after the read strobe appears, well before the sampling edge.
	assign prdy = (hold_reg == 3'h0);
endmodule

// >>> verif/cpu_to_s100_bus_adapter_bench.sv
// Self-checking bench for the processor to system bus adapter.
`timescale 1ns/10ps

`include "cs100_map.svh"

module cpu_to_s100_bus_adapter_bench;
	logic        aclk = 1'b0;
	logic        aresetn, slow, phase2;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] cpu_addr, bus_addr;
	logic [7:0]  cpu_dout, cpu_din, bus_dout, bus_din;
	logic        opcode_fetch_n, mem_request_n, io_request_n, cpu_rd_n, cpu_wr_n, cpu_refresh_n, cpu_halt_n;
	logic        cpu_bus_grant_n, cpu_wait_n, reset_bus_n, addr_dsb_n, dout_dsb_n, xrdy, prdy, rom_select;
	logic        bus_addr_oe, bus_dout_oe, bus_din_en, bus_sync, bus_wr_n, bus_dbin, bus_inte, bus_hlda;
	logic        bus_wait, bus_inta, wbad, wt;
	logic [6:0]  ctrl;
	logic [4:0]  code [3] = '{5'b10110, 5'b10101, 5'b11001};
	logic [15:0] ia [6] = '{16'h0000, 16'h0002, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
	logic [4:0]  ic [6] = '{5'b00101, 5'b00101, 5'b00101, 5'b00101, 5'b01011, 5'b00101};
	logic        ie [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	int          failures = 0, compares = 0, ph = 0, n;

	cs100_adapter u_cs100_adapter (.*);
	cs100_bus_board u_cs100_bus_board (.*);

	// The processor clock is slow next to aclk, so one phase spans 25 cycles.
	always #2.5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		ph <= (ph + 1) % 50;
		phase2 <= (ph < 25);
	end

	// --------------------------------------------------------------------
	// Checking and bus tasks
	// --------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask

	task automatic report_and_stop;
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Address and data are offered together and each is dropped once taken.
	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa, pw;
		@(posedge aclk);
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa | pw)
		begin
			@(negedge aclk);
			pa = pa & ~s_axi_awready;
			pw = pw & ~s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		do
			@(negedge aclk);
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(negedge aclk);
		while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do
			@(negedge aclk);
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask

	// One processor cycle; strobes are {fetch, mem, io, rd, wr}, all active low.
	task automatic cyc(input logic [15:0] a, input logic [4:0] s);
		@(posedge aclk);
		cpu_addr <= a;
		{opcode_fetch_n, mem_request_n, io_request_n, cpu_rd_n, cpu_wr_n} <= s;
		repeat (30) @(posedge aclk);
		{opcode_fetch_n, mem_request_n, io_request_n, cpu_rd_n, cpu_wr_n} <= 5'h1F;
		repeat (30) @(posedge aclk);
	endtask

	// Holds a cycle long enough to see the whole sync pulse and the write strobe after it.
	task automatic watch(input logic [4:0] s);
		@(posedge aclk);
		{opcode_fetch_n, mem_request_n, io_request_n, cpu_rd_n, cpu_wr_n} <= s;
		n = 0;
		wbad = 1'b0;
		wt = 1'b0;
		repeat (100)
		begin
			@(negedge aclk);
			if (bus_sync === 1'b1)
				n++;
			wbad |= bus_sync & ~bus_wr_n;
			wt |= bus_wait;
		end
		chb("bus_wr_n", s[0], bus_wr_n);
		@(posedge aclk);
		{opcode_fetch_n, mem_request_n, io_request_n, cpu_rd_n, cpu_wr_n} <= 5'h1F;
		repeat (20) @(posedge aclk);
	endtask

	function automatic logic [15:0] exp_addr(input logic [15:0] a, input logic m, input logic io, input logic f);
		return (m & ~io & f) ? {a[7:0], a[7:0]} : a;
	endfunction

	function automatic logic exp_din(input logic [6:0] c, input logic rdn, input logic ack, input logic g);
		return (~rdn | ack | ~g) & ~(c[3] | c[4] | c[5] | (c[2] & rom_select));
	endfunction

	// --------------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------------
	initial
	begin
		void'($urandom(32'hEFB733D9));
		{aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hF};
		{cpu_addr, cpu_dout, rom_select} = 25'h0;
		{opcode_fetch_n, mem_request_n, io_request_n, cpu_rd_n, cpu_wr_n, cpu_refresh_n, cpu_halt_n} = 7'h7F;
		{cpu_bus_grant_n, reset_bus_n, addr_dsb_n, dout_dsb_n, xrdy} = 5'h1F;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`CS100_CTRL_OFS, rd, rsp);
		chk("ctrl_reset", `CS100_CTRL_RST, rd);
		axr(12'h010, rd, rsp);
		chk("unmapped_rresp", {30'h0, `CS100_RESP_SLVERR}, {30'h0, rsp});
		chk("unmapped_rdata", 32'h0, rd);
		axw(12'h010, 32'hFFFF_FFFF, rsp);
		chk("unmapped_bresp", {30'h0, `CS100_RESP_SLVERR}, {30'h0, rsp});
		// Random pin patterns with periodic random control settings.
		for (int i = 0; i < 150; i++)
		begin
			if (i % 15 == 0)
			begin
				ctrl = 7'($urandom);
				axw(`CS100_CTRL_OFS, {25'h0, ctrl}, rsp);
				axr(`CS100_CTRL_OFS, rd, rsp);
				chk("ctrl", {25'h0, ctrl}, rd);
			end
			@(posedge aclk);
			{cpu_addr, cpu_dout} <= 24'($urandom);
			{opcode_fetch_n, io_request_n, cpu_rd_n, cpu_bus_grant_n} <= 4'($urandom);
			{addr_dsb_n, dout_dsb_n, rom_select, cpu_halt_n} <= 4'($urandom);
			repeat (10) @(posedge aclk);
			@(negedge aclk);
			chk("bus_addr", {16'h0, exp_addr(cpu_addr, ctrl[0], io_request_n, opcode_fetch_n)}, {16'h0, bus_addr});
			chb("bus_addr_oe", addr_dsb_n, bus_addr_oe);
			chb("bus_dout_oe", dout_dsb_n, bus_dout_oe);
			chb("bus_hlda", ~cpu_bus_grant_n, bus_hlda);
			chb("bus_inta", ~opcode_fetch_n & ~io_request_n, bus_inta);
			chb("bus_dbin", ~cpu_rd_n | (~opcode_fetch_n & ~io_request_n), bus_dbin);
			chb("bus_din_en", exp_din(ctrl, cpu_rd_n, ~opcode_fetch_n & ~io_request_n, cpu_bus_grant_n), bus_din_en);
			chk("cpu_din", {24'h0, bus_din}, {24'h0, cpu_din});
			if (bus_sync === 1'b0)
				chk("bus_dout", {24'h0, cpu_dout}, {24'h0, bus_dout});
		end
		axr(`CS100_STATUS_OFS, rd, rsp);
		chb("status_hlda", ~cpu_bus_grant_n, rd[`CS100_ST_HLDA]);
		axw(`CS100_CTRL_OFS, 32'h1, rsp);
		@(posedge aclk);
		{cpu_bus_grant_n, addr_dsb_n, dout_dsb_n, rom_select} <= 4'hE;
		{opcode_fetch_n, io_request_n, cpu_rd_n} <= 3'h7;
		repeat (30) @(posedge aclk);
		// Memory write, memory read and I/O read each give one bounded sync pulse.
		for (int k = 0; k < 3; k++)
		begin
			watch(code[k]);
			chb("sync_len", 1'b1, n > 0 && n <= 52);
			chb("wr_in_sync", 1'b0, wbad);
			chb("wait_idle", 1'b0, wt);
		end
		@(posedge aclk);
		cpu_refresh_n <= 1'b0;
		watch(5'b10111);
		chb("refresh_sync", 1'b0, n > 0);
		cpu_refresh_n <= 1'b1;
		slow <= 1'b1;
		watch(5'b00101);
		chb("slow_wait", 1'b1, wt);
		slow <= 1'b0;
		// Ready held low raises wait within eight clocks; it falls only after release.
		@(posedge aclk);
		xrdy <= 1'b0;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
		chb("wait_set", 1'b1, bus_wait);
		chb("cpu_wait_n", 1'b0, cpu_wait_n);
		@(posedge aclk);
		xrdy <= 1'b1;
		repeat (40) @(posedge aclk);
		@(negedge aclk);
		chb("wait_clear", 1'b0, bus_wait);
		// Opcode fetches set and clear the interrupt flag; a plain byte leaves it alone.
		for (int k = 0; k < 6; k++)
		begin
			cyc(ia[k], ic[k]);
			@(negedge aclk);
			chb("bus_inte", ie[k], bus_inte);
		end
		reset_bus_n <= 1'b0;
		repeat (10) @(posedge aclk);
		reset_bus_n <= 1'b1;
		@(negedge aclk);
		chb("inte_reset", 1'b0, bus_inte);
		report_and_stop;
	end

	// Cuts a hung run short well beyond the expected length.
	initial
	begin
		repeat (40000) @(posedge aclk);
		failures++;
		report_and_stop;
	end
endmodule
